// [logic/perf_monitor_pkg.sv]
// Constants, field layouts and carrier types for the performance monitor block
`default_nettype none
package perf_monitor_pkg;
    // Register addresses
    localparam logic [31:0] ADDR_PERF_MONITOR_CONTROL = 32'hffe08000;
    localparam logic [31:0] ADDR_PERF_COUNT0 = 32'hffe08100;
    localparam logic [31:0] ADDR_PERF_COUNT1 = 32'hffe08104;
    localparam logic [31:0] ADDR_CORE_IDENTIFICATION = 32'hffe05000;
    localparam logic [31:0] ADDR_SYSTEM_CONFIG = 32'hffe0f000;
    localparam logic [31:0] ADDR_CYCLE_COUNT_LOW = 32'hffe0f004;
    localparam logic [31:0] ADDR_CYCLE_COUNT_HIGH = 32'hffe0f008;

    // Control register field positions
    localparam int CTL_POWER_BIT = 0;
    localparam int CTL_KIND0_BIT = 1;
    localparam int CTL_MODE0_LSB = 2;
    localparam int CTL_SEL0_LSB = 4;
    localparam int CTL_EDGE0_BIT = 15;
    localparam int CTL_KIND1_BIT = 16;
    localparam int CTL_MODE1_LSB = 17;
    localparam int CTL_SEL1_LSB = 19;
    localparam int CTL_EDGE1_BIT = 31;
    localparam logic [31:0] CTL_RESET = 32'h00000000;
    // Unused control bits 30:27 and 14:12 read back as zero
    localparam logic [31:0] CTL_WRITE_MASK = 32'h87ff8fff;

    // System configuration fields
    localparam int CFG_CYCLE_COUNT_ENABLE_BIT = 1;
    localparam int CFG_SSTEP_BIT = 0;
    localparam logic [31:0] CFG_RESET = 32'h00000030;

    // Identification value, arbitrary
    localparam logic [31:0] CORE_ID_DEFAULT = 32'h0a5a0001;

    // Mode enable encodings
    localparam logic [1:0] MODE_EN_NEVER = 2'h0;
    localparam logic [1:0] MODE_EN_USER = 2'h1;
    localparam logic [1:0] MODE_EN_SUPER = 2'h2;
    localparam logic [1:0] MODE_EN_BOTH = 2'h3;

    // Event codes
    localparam logic [7:0] EV_LOOP0 = 8'h00;
    localparam logic [7:0] EV_LOOP1 = 8'h01;
    localparam logic [7:0] EV_LBUF0 = 8'h02;
    localparam logic [7:0] EV_LBUF1 = 8'h03;
    localparam logic [7:0] EV_SWEXC = 8'h0a;
    localparam logic [7:0] EV_SYNC = 8'h0b;
    localparam logic [7:0] EV_COMMIT = 8'h0c;
    localparam logic [7:0] EV_IRQ = 8'h0d;
    localparam logic [7:0] EV_MISALIGN = 8'h0e;
    localparam logic [7:0] EV_AGEN_RAW = 8'h10;
    localparam logic [7:0] EV_COMP_RAW = 8'h13;
    localparam logic [7:0] EV_FETCH_DMA = 8'h80;
    localparam logic [7:0] EV_PROC_STALL = 8'h90;
    localparam logic [7:0] EV_UNHIDDEN = 8'h91;
    localparam logic [7:0] EV_STORE_FULL = 8'h92;
    localparam logic [7:0] EV_WRITE_FULL = 8'h93;
    localparam logic [7:0] EV_STORE_FWD = 8'h94;
    localparam logic [7:0] EV_FILL_BUF = 8'h95;
    localparam logic [7:0] EV_ARRAY_TAG = 8'h96;
    localparam logic [7:0] EV_ARRAY = 8'h97;
    localparam logic [7:0] EV_DMEM_STALL = 8'h98;
    localparam logic [7:0] EV_FILL_A = 8'h99;
    localparam logic [7:0] EV_FILL_B = 8'h9a;
    localparam logic [7:0] EV_VICTIM_A = 8'h9b;
    localparam logic [7:0] EV_VICTIM_B = 8'h9c;
    localparam logic [7:0] EV_FILL_HI = 8'h9d;
    localparam logic [7:0] EV_FILL_LO = 8'h9e;
    localparam logic [1:0] WEIGHT_NORMAL = 2'h1;
    localparam logic [1:0] WEIGHT_FETCH_DMA = 2'h2;

    typedef enum logic [1:0] {
        MODE_USER = 2'b00,
        MODE_SUPERVISOR = 2'b01,
        MODE_EMULATOR = 2'b11
    } core_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic loop0_iter;
        logic loop1_iter;
        logic loopbuf0_unopt;
        logic loopbuf1_unopt;
        logic software_exception_instr;
        logic core_sync_instr;
        logic system_sync_instr;
        logic committed;
        logic interrupt_taken;
        logic misaligned;
        logic address_generator_raw_stall;
        logic compute_raw_stall;
        logic fetch_dma_postponed;
        logic proc_mem_stall;
        logic dmem_unhidden_stall;
        logic store_buf_full;
        logic write_buf_full;
        logic store_fwd_stall;
        logic fill_buf_stall;
        logic array_tag_collision;
        logic array_collision;
        logic dmem_stall;
        logic fill_bank_a;
        logic fill_bank_b;
        logic victim_bank_a;
        logic victim_bank_b;
        logic fill_hi_req;
        logic fill_lo_req;
    } core_events_t;

    typedef struct packed {
        logic retired;
        logic in_interrupt_handler;
        logic in_exception_or_higher;
    } step_status_t;
endpackage : perf_monitor_pkg
`default_nettype wire

// [logic/perf_event_counter.sv]
// One performance counter with event selection, mode gating and count-down event
`default_nettype none
module perf_event_counter (
    input wire logic clk,
    input wire logic nrst,
    input wire logic monitor_power_on,
    input wire logic [1:0] mode_enable,
    input wire logic edge_select,
    input wire logic event_kind,
    input wire logic [7:0] event_select,
    input wire perf_monitor_pkg::core_mode_t mode,
    input wire perf_monitor_pkg::core_events_t events,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic [31:0] count,
    output logic exception_pulse,
    output logic emulation_pulse
);
    import perf_monitor_pkg::*;

    logic ev;
    logic ev_prev;
    logic mode_ok;
    logic qualifies;
    logic [1:0] weight;
    logic [32:0] sum;
    logic step;

    always_comb begin
        ev = 1'b0;
        case (event_select)
            EV_LOOP0: ev = events.loop0_iter;
            EV_LOOP1: ev = events.loop1_iter;
            EV_LBUF0: ev = events.loopbuf0_unopt;
            EV_LBUF1: ev = events.loopbuf1_unopt;
            EV_SWEXC: ev = events.software_exception_instr;
            EV_SYNC: ev = events.core_sync_instr | events.system_sync_instr;
            EV_COMMIT: ev = events.committed;
            EV_IRQ: ev = events.interrupt_taken;
            EV_MISALIGN: ev = events.misaligned;
            EV_AGEN_RAW: ev = events.address_generator_raw_stall;
            EV_COMP_RAW: ev = events.compute_raw_stall;
            EV_FETCH_DMA: ev = events.fetch_dma_postponed;
            EV_PROC_STALL: ev = events.proc_mem_stall;
            EV_UNHIDDEN: ev = events.dmem_unhidden_stall;
            EV_DMEM_STALL: ev = events.dmem_stall;
            EV_STORE_FULL: ev = events.store_buf_full;
            EV_WRITE_FULL: ev = events.write_buf_full;
            EV_STORE_FWD: ev = events.store_fwd_stall;
            EV_FILL_BUF: ev = events.fill_buf_stall;
            EV_ARRAY_TAG: ev = events.array_tag_collision;
            EV_ARRAY: ev = events.array_collision;
            EV_FILL_A: ev = events.fill_bank_a;
            EV_FILL_B: ev = events.fill_bank_b;
            EV_VICTIM_A: ev = events.victim_bank_a;
            EV_VICTIM_B: ev = events.victim_bank_b;
            EV_FILL_HI: ev = events.fill_hi_req;
            EV_FILL_LO: ev = events.fill_lo_req;
            default: ev = 1'b0;
        endcase
    end

    assign mode_ok = (mode == MODE_USER && mode_enable[0])
        || (mode == MODE_SUPERVISOR && mode_enable[1]);
    assign qualifies = edge_select ? (ev && !ev_prev) : ev;
    assign step = monitor_power_on && mode_ok && qualifies;
    assign weight = (event_select == EV_FETCH_DMA) ? WEIGHT_FETCH_DMA : WEIGHT_NORMAL;
    assign sum = {1'b0, count} + {31'h0, weight};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0;
        end else if (wr_en) begin
            count <= wdata;
        end else if (step) begin
            count <= sum[31:0];
        end
    end

    // Edge history keeps running so enabling mid-event does not fake an edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev_prev <= 1'b0;
        end else begin
            ev_prev <= ev;
        end
    end

    // Wrap raises exception or emulation event
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            exception_pulse <= 1'b0;
            emulation_pulse <= 1'b0;
        end else begin
            exception_pulse <= step && !wr_en && sum[32] && !event_kind;
            emulation_pulse <= step && !wr_en && sum[32] && event_kind;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_power_off_hold: assert property (!monitor_power_on && !wr_en |=> count == $past(count))
        else $error("counter moved while monitor unpowered");
    chk_mode_never: assert property (mode_enable == MODE_EN_NEVER && !wr_en |=> $stable(count))
        else $error("counter moved with mode enable off");
    chk_edge_only: assert property (edge_select && ev && ev_prev && !wr_en |=> $stable(count))
        else $error("edge mode counted a held level");
    chk_wrap_kind: assert property (step && !wr_en && count == 32'hffffffff
        |=> (exception_pulse != event_kind) && (emulation_pulse == event_kind))
        else $error("count-down event kind wrong");
    chk_dma_weight: assert property (step && !wr_en && event_select == EV_FETCH_DMA
        |=> count == $past(count) + 32'h2)
        else $error("postponed fetch did not add two");
    chk_level_step: assert property (monitor_power_on && mode_ok && !edge_select && ev
        && !wr_en && event_select == EV_COMMIT |=> count == $past(count) + 32'h1)
        else $error("level event did not add one");
endmodule : perf_event_counter
`default_nettype wire

// [logic/perf_monitor_cycle_counter.sv]
// Performance monitor with two event counters, cycle counter, config and id registers
//
// How it works
// - Counter enables ignored until power bit set
// - Mode enable: never, user, supervisor, both
// - Edge bit: count level cycles or edges
// - Count-down raises exception or emulation event
// - Eight-bit event code picks counted event
// - Codes 00-03 count loop events
// - Codes 0A-0E count instruction and exception events
// - Codes 10, 13 count hazard stalls
// - Code 80 counts fetch postponements, two each
// - Codes 90, 91, 98 count memory stalls
// - Codes 92-95 count buffer stalls
// - Codes 96, 97 count collision stalls
// - Codes 99-9C count fills and victims
// - Codes 9D, 9E count fill requests
// - Cycle count runs in user/supervisor, holds emulator
// - Cycle count split into low, high words
// - Low read latches high word into shadow
// - User mode reads cycles, cannot write
// - Cycle count runs only with enable bit
// - Config resets to 30h, supervisor access only
// - Single-step traps after user or handler instruction
// - Identification register is read-only
// - Two 32-bit counter registers hold counts
`default_nettype none
module perf_monitor_cycle_counter #(
    parameter logic [31:0] CORE_ID = perf_monitor_pkg::CORE_ID_DEFAULT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire perf_monitor_pkg::reg_req_t req,
    input wire perf_monitor_pkg::core_mode_t mode,
    input wire perf_monitor_pkg::core_events_t events,
    input wire perf_monitor_pkg::step_status_t step_status,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic perf_exception,
    output logic perf_emulation,
    output logic single_step_exception,
    output logic cycle_count_enable
);
    import perf_monitor_pkg::*;

    logic [31:0] perf_monitor_control;
    logic [31:0] system_config;
    logic [63:0] cycles;
    logic [31:0] cycle_count_high;
    logic [31:0] perf_count0;
    logic [31:0] perf_count1;
    logic exc0;
    logic exc1;
    logic emu0;
    logic emu1;

    // Address decode
    logic hit_ctl;
    logic hit_cnt0;
    logic hit_cnt1;
    logic hit_id;
    logic hit_cfg;
    logic hit_low;
    logic hit_high;
    logic rd;
    logic wr;
    logic is_user;
    logic cfg_ok;
    logic cyc_wr_ok;
    logic cyc_run;
    logic [31:0] next_rd_data;
    logic [63:0] cycles_inc;

    assign rd = req.valid && !req.write;
    assign wr = req.valid && req.write;
    assign hit_ctl = req.addr == ADDR_PERF_MONITOR_CONTROL;
    assign hit_cnt0 = req.addr == ADDR_PERF_COUNT0;
    assign hit_cnt1 = req.addr == ADDR_PERF_COUNT1;
    assign hit_id = req.addr == ADDR_CORE_IDENTIFICATION;
    assign hit_cfg = req.addr == ADDR_SYSTEM_CONFIG;
    assign hit_low = req.addr == ADDR_CYCLE_COUNT_LOW;
    assign hit_high = req.addr == ADDR_CYCLE_COUNT_HIGH;
    assign is_user = mode == MODE_USER;
    assign cfg_ok = mode == MODE_SUPERVISOR;
    // User mode writes to cycles dropped
    assign cyc_wr_ok = wr && !is_user;
    assign cyc_run = system_config[CFG_CYCLE_COUNT_ENABLE_BIT] && mode != MODE_EMULATOR;
    assign cycles_inc = cycles + 64'h1;

    // Read data select; unmapped or forbidden reads return zero
    always_comb begin
        next_rd_data = 32'h0;
        if (hit_ctl) begin
            next_rd_data = perf_monitor_control;
        end else if (hit_cnt0) begin
            next_rd_data = perf_count0;
        end else if (hit_cnt1) begin
            next_rd_data = perf_count1;
        end else if (hit_id) begin
            next_rd_data = CORE_ID;
        end else if (hit_cfg && cfg_ok) begin
            next_rd_data = system_config;
        end else if (hit_low) begin
            next_rd_data = cycles[31:0];
        end else if (hit_high) begin
            next_rd_data = cycle_count_high;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_valid <= 1'b0;
            rd_data <= 32'h0;
        end else begin
            rd_valid <= rd;
            rd_data <= rd ? next_rd_data : 32'h0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            perf_monitor_control <= CTL_RESET;
        end else if (wr && hit_ctl) begin
            perf_monitor_control <= req.wdata & CTL_WRITE_MASK;
        end
    end

    // Config reset value and supervisor-only writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            system_config <= CFG_RESET;
        end else if (wr && hit_cfg && cfg_ok) begin
            system_config <= req.wdata;
        end
    end

    // Free-running count gated by enable; write takes the word it hits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cycles <= 64'h0;
        end else if (cyc_wr_ok && hit_low) begin
            cycles <= {cycles[63:32], req.wdata};
        end else if (cyc_wr_ok && hit_high) begin
            cycles <= {req.wdata, cyc_run ? cycles_inc[31:0] : cycles[31:0]};
        end else if (cyc_run) begin
            cycles <= cycles_inc;
        end
    end

    // Shadow only moves on a low-word read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cycle_count_high <= 32'h0;
        end else if (rd && hit_low) begin
            cycle_count_high <= cycles[63:32];
        end
    end

    // Single-step trap, suppressed inside exception service
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            single_step_exception <= 1'b0;
        end else begin
            single_step_exception <= system_config[CFG_SSTEP_BIT] && step_status.retired
                && !step_status.in_exception_or_higher
                && (is_user || (mode == MODE_SUPERVISOR && step_status.in_interrupt_handler));
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            perf_exception <= 1'b0;
            perf_emulation <= 1'b0;
            cycle_count_enable <= 1'b0;
        end else begin
            perf_exception <= exc0 || exc1;
            perf_emulation <= emu0 || emu1;
            cycle_count_enable <= system_config[CFG_CYCLE_COUNT_ENABLE_BIT];
        end
    end

    perf_event_counter u_counter0 (
        .clk(clk),
        .nrst(nrst),
        .monitor_power_on(perf_monitor_control[CTL_POWER_BIT]),
        .mode_enable(perf_monitor_control[CTL_MODE0_LSB +: 2]),
        .edge_select(perf_monitor_control[CTL_EDGE0_BIT]),
        .event_kind(perf_monitor_control[CTL_KIND0_BIT]),
        .event_select(perf_monitor_control[CTL_SEL0_LSB +: 8]),
        .mode(mode),
        .events(events),
        .wr_en(wr && hit_cnt0),
        .wdata(req.wdata),
        .count(perf_count0),
        .exception_pulse(exc0),
        .emulation_pulse(emu0)
    );

    perf_event_counter u_counter1 (
        .clk(clk),
        .nrst(nrst),
        .monitor_power_on(perf_monitor_control[CTL_POWER_BIT]),
        .mode_enable(perf_monitor_control[CTL_MODE1_LSB +: 2]),
        .edge_select(perf_monitor_control[CTL_EDGE1_BIT]),
        .event_kind(perf_monitor_control[CTL_KIND1_BIT]),
        .event_select(perf_monitor_control[CTL_SEL1_LSB +: 8]),
        .mode(mode),
        .events(events),
        .wr_en(wr && hit_cnt1),
        .wdata(req.wdata),
        .count(perf_count1),
        .exception_pulse(exc1),
        .emulation_pulse(emu1)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence low_read_s;
        rd && hit_low;
    endsequence

    sequence high_read_s;
        rd && hit_high && !hit_low;
    endsequence

    chk_cycle_run: assert property (cyc_run && !(cyc_wr_ok && (hit_low || hit_high))
        |=> cycles == $past(cycles) + 64'h1)
        else $error("cycle counter did not advance");
    chk_cycle_emu_hold: assert property (mode == MODE_EMULATOR && !(cyc_wr_ok && (hit_low
        || hit_high)) |=> $stable(cycles))
        else $error("cycle counter moved in emulator mode");
    chk_shadow_read: assert property (high_read_s
        |=> rd_valid && rd_data == $past(cycle_count_high))
        else $error("high read did not return shadow");
    chk_shadow_load: assert property (low_read_s |=> cycle_count_high == $past(cycles[63:32]))
        else $error("shadow not loaded on low read");
    chk_user_write: assert property (is_user && wr && (hit_low || hit_high) && !cyc_run
        |=> $stable(cycles))
        else $error("user write changed cycle count");
    chk_cfg_guard: assert property (!cfg_ok && wr && hit_cfg |=> $stable(system_config))
        else $error("config written outside supervisor");
    chk_step_trap: assert property (system_config[CFG_SSTEP_BIT] && step_status.retired
        && is_user && !step_status.in_exception_or_higher |=> single_step_exception)
        else $error("single-step trap missing");
    chk_step_ignore: assert property (step_status.in_exception_or_higher
        |=> !single_step_exception)
        else $error("single-step trap during exception");
    chk_id_read: assert property (rd && hit_id |=> rd_valid && rd_data == CORE_ID)
        else $error("identification value wrong");
endmodule : perf_monitor_cycle_counter
`default_nettype wire

// [verif/test_perf_monitor_cycle_counter.sv]
// Self-checking bench for the performance monitor and cycle counter block
`default_nettype none
module test_perf_monitor_cycle_counter;
    timeunit 1ns;
    timeprecision 1ps;
    import perf_monitor_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    reg_req_t req = '0;
    core_mode_t mode = MODE_SUPERVISOR;
    core_events_t events = '0;
    step_status_t step_status = '0;
    logic rd_valid, perf_exception, perf_emulation, single_step_exception, cycle_count_enable;
    logic [31:0] rd_data, a, b, c;
    int fails = 0;
    int checks_done = 0;
    // Event codes in the order of the event carrier fields
    logic [7:0] codes [28] = '{EV_LOOP0, EV_LOOP1, EV_LBUF0, EV_LBUF1, EV_SWEXC, EV_SYNC,
        EV_SYNC, EV_COMMIT, EV_IRQ, EV_MISALIGN, EV_AGEN_RAW, EV_COMP_RAW, EV_FETCH_DMA,
        EV_PROC_STALL, EV_UNHIDDEN, EV_STORE_FULL, EV_WRITE_FULL, EV_STORE_FWD, EV_FILL_BUF,
        EV_ARRAY_TAG, EV_ARRAY, EV_DMEM_STALL, EV_FILL_A, EV_FILL_B, EV_VICTIM_A, EV_VICTIM_B,
        EV_FILL_HI, EV_FILL_LO};
    core_events_t ev_commit = core_events_t'(28'h0100000);

    perf_monitor_cycle_counter u_dut (.clk(clk), .nrst(nrst), .req(req), .mode(mode),
        .events(events), .step_status(step_status), .rd_valid(rd_valid), .rd_data(rd_data),
        .perf_exception(perf_exception), .perf_emulation(perf_emulation),
        .single_step_exception(single_step_exception), .cycle_count_enable(cycle_count_enable));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Each access takes two cycles so valid never toggles twice in one step
    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        req = '{1'b1, 1'b1, ad, d};
        @(negedge clk);
        req.valid = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [31:0] ad, output logic [31:0] d);
        req = '{1'b1, 1'b0, ad, 32'h0};
        @(negedge clk);
        req.valid = 1'b0;
        chk({31'h0, rd_valid}, 32'h1);
        d = rd_data;
        @(negedge clk);
    endtask : rd

    function automatic logic [31:0] ctl(input logic p, input logic [1:0] m, input logic [7:0] s,
        input logic e, input logic k);
        return {16'h0, e, 3'h0, s, m, k, p};
    endfunction : ctl

    task automatic ev_run(input logic [31:0] cv, input core_mode_t md, input core_events_t ev,
        input int n, input logic [31:0] exp);
        logic [31:0] d;
        wr(ADDR_PERF_COUNT0, 32'h0);
        wr(ADDR_PERF_MONITOR_CONTROL, cv);
        mode = md;
        events = ev;
        repeat (n) @(negedge clk);
        events = '0;
        mode = MODE_SUPERVISOR;
        @(negedge clk);
        rd(ADDR_PERF_COUNT0, d);
        chk(d, exp);
    endtask : ev_run

    task automatic wrap(input logic k);
        logic [1:0] seen;
        seen = 2'b00;
        wr(ADDR_PERF_MONITOR_CONTROL, ctl(1'b1, MODE_EN_BOTH, EV_COMMIT, 1'b0, k));
        wr(ADDR_PERF_COUNT0, 32'hffffffff);
        events = ev_commit;
        repeat (4) begin
            @(negedge clk);
            events = '0;
            seen = seen | {perf_exception, perf_emulation};
        end
        chk({30'h0, seen}, k ? 32'h1 : 32'h2);
    endtask : wrap

    // Second monitor lives in the upper control half; monitor 0 is powered but its mode enable is left at never
    task automatic count1_run();
        logic [31:0] d;
        wr(ADDR_PERF_COUNT1, 32'h0);
        wr(ADDR_PERF_MONITOR_CONTROL, {1'b0, 4'h0, EV_COMMIT, MODE_EN_BOTH, 1'b1, 16'h0001});
        events = ev_commit;
        repeat (3) @(negedge clk);
        events = '0;
        @(negedge clk);
        rd(ADDR_PERF_COUNT1, d);
        chk(d, 32'h3);
        rd(ADDR_PERF_COUNT0, d);
        chk(d, 32'h0);
        $display("test second counter finished");
    endtask : count1_run

    task automatic step(input core_mode_t md, input step_status_t st, input logic exp);
        logic seen;
        seen = 1'b0;
        mode = md;
        step_status = st;
        repeat (3) begin
            @(negedge clk);
            step_status = '0;
            seen = seen | single_step_exception;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask : step

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        forever #10 clk = ~clk;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        rd(ADDR_SYSTEM_CONFIG, a);
        chk(a, 32'h00000030);
        wr(ADDR_CORE_IDENTIFICATION, 32'h0);
        rd(ADDR_CORE_IDENTIFICATION, a);
        chk(a, CORE_ID_DEFAULT);
        rd(32'hffe0fff0, a);
        chk(a, 32'h0);
        $display("test registers finished");
        for (int k = 0; k < 28; k++) begin
            c = ctl(1'b1, MODE_EN_BOTH, codes[k], 1'b0, 1'b0);
            b = (codes[k] == EV_FETCH_DMA) ? 32'h2 : 32'h1;
            ev_run(c, MODE_SUPERVISOR, core_events_t'(28'h8000000 >> k), 1, b);
        end
        $display("test event codes finished");
        for (int m = 0; m < 4; m++) begin
            c = ctl(1'b1, 2'(m), EV_COMMIT, 1'b0, 1'b0);
            ev_run(c, MODE_USER, ev_commit, 3, m[0] ? 32'h3 : 32'h0);
            ev_run(c, MODE_SUPERVISOR, ev_commit, 3, m[1] ? 32'h3 : 32'h0);
        end
        ev_run(ctl(1'b0, MODE_EN_BOTH, EV_COMMIT, 1'b0, 1'b0), MODE_USER, ev_commit, 3, 0);
        ev_run(ctl(1'b1, MODE_EN_BOTH, EV_COMMIT, 1'b1, 1'b0), MODE_USER, ev_commit, 3, 1);
        wrap(1'b0);
        wrap(1'b1);
        $display("test counter modes finished");
        count1_run();
        wr(ADDR_SYSTEM_CONFIG, 32'h32);
        wr(ADDR_CYCLE_COUNT_HIGH, 32'h7);
        wr(ADDR_CYCLE_COUNT_LOW, 32'hfffffff8);
        chk({31'h0, cycle_count_enable}, 32'h1);
        rd(ADDR_CYCLE_COUNT_LOW, a);
        repeat (10) @(negedge clk);
        rd(ADDR_CYCLE_COUNT_HIGH, b);
        chk(b, 32'h7);
        rd(ADDR_CYCLE_COUNT_LOW, a);
        rd(ADDR_CYCLE_COUNT_HIGH, b);
        chk(b, 32'h8);
        rd(ADDR_CYCLE_COUNT_LOW, b);
        // Each access takes two cycles, so two reads span four
        chk(b - a, 32'h4);
        mode = MODE_EMULATOR;
        rd(ADDR_CYCLE_COUNT_LOW, a);
        rd(ADDR_CYCLE_COUNT_LOW, b);
        chk(b - a, 32'h0);
        mode = MODE_SUPERVISOR;
        wr(ADDR_SYSTEM_CONFIG, 32'h30);
        rd(ADDR_CYCLE_COUNT_LOW, a);
        rd(ADDR_CYCLE_COUNT_LOW, b);
        chk(b - a, 32'h0);
        chk({31'h0, cycle_count_enable}, 32'h0);
        mode = MODE_USER;
        wr(ADDR_CYCLE_COUNT_LOW, 32'h0);
        rd(ADDR_CYCLE_COUNT_LOW, a);
        chk(a, b);
        wr(ADDR_SYSTEM_CONFIG, 32'h0);
        rd(ADDR_SYSTEM_CONFIG, a);
        chk(a, 32'h0);
        mode = MODE_SUPERVISOR;
        rd(ADDR_SYSTEM_CONFIG, a);
        chk(a, 32'h00000030);
        $display("test cycle counter finished");
        wr(ADDR_SYSTEM_CONFIG, 32'h31);
        step(MODE_USER, 3'b100, 1'b1);
        step(MODE_SUPERVISOR, 3'b100, 1'b0);
        step(MODE_SUPERVISOR, 3'b110, 1'b1);
        step(MODE_USER, 3'b101, 1'b0);
        $display("test single step finished");
        end_of_test();
    end
endmodule : test_perf_monitor_cycle_counter
`default_nettype wire
